// ---- design/sbtt_pkg.sv ----
// Package for the secondary bus target termination block.
// Assumes a single 125 MHz secondary bus clock and synchronous reset.
package sbtt_pkg;

  // ***********************************************************************
  // Encodings and constants
  // ***********************************************************************
  localparam logic ASSERTED_L = 1'h0;
  localparam logic DEASSERTED_L = 1'h1;
  localparam logic [3:0] SERR_EVT_W = 4'h3;
  localparam logic [1:0] SYNC_ZERO = 2'h3;

  typedef enum logic [1:0] {
    SBTT_TERM_NONE,
    SBTT_TERM_RETRY,
    SBTT_TERM_ABORT,
    SBTT_TERM_DISC
  } sbtt_term_t;

  typedef enum logic [1:0] {
    SBTT_REQ_TRDY,
    SBTT_REQ_DISC_DATA,
    SBTT_REQ_DISC_NODATA,
    SBTT_REQ_ABORT
  } sbtt_req_t;

  // Open-drain or sustained tristate pin: out and enable.
  typedef struct packed {
    logic o;
    logic oe;
  } sbtt_pin_t;

  // Upstream delayed transaction error events, one-cycle pulses.
  typedef struct packed {
    logic dwr_discard;
    logic drd_discard;
    logic dly_timeout;
  } sbtt_evt_t;

  // Target-side request from the bridge core.
  typedef struct packed {
    logic active;
    logic is_write;
    logic ready;
    sbtt_req_t kind;
  } sbtt_treq_t;

endpackage : sbtt_pkg

// ---- design/sbtt_sync.sv ----
// Two-stage synchroniser for one bus pin level.
// Assumes the input may change at any time relative to clk.
module sbtt_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Level
  input wire logic din,
  output logic dout
);
  import sbtt_pkg::*;

  typedef struct packed {
    logic [1:0] stage;
  } sbtt_sync_state_t;

  sbtt_sync_state_t state, next_state;

  always_comb begin
    next_state.stage = {state.stage[0], din};
    if (sys_rst) begin
      next_state.stage = SYNC_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign dout = state.stage[1];

endmodule : sbtt_sync

// ---- design/sbtt_serr.sv ----
// System-error generator and forwarder for the secondary side.
// Assumes event pulses and enables come from logic on clk.
module sbtt_serr (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Events and configuration
  input wire sbtt_pkg::sbtt_evt_t evt,
  input wire logic [2:0] evt_en,
  input wire logic fwd_en,
  input wire logic serr_l_sync,
  // Outputs
  output sbtt_pkg::sbtt_pin_t s_serr,
  output logic p_serr_l
);
  import sbtt_pkg::*;

  typedef struct packed {
    logic [3:0] hold;
    logic p_out;
  } sbtt_serr_state_t;

  sbtt_serr_state_t state, next_state;
  logic fire;

  always_comb begin
    fire = |(evt & evt_en); // R1 R2
    next_state = state;
    if (fire) begin
      next_state.hold = SERR_EVT_W;
    end else if (state.hold != 4'h0) begin
      next_state.hold = state.hold - 4'h1;
    end
    next_state.p_out = !(fwd_en && serr_l_sync == ASSERTED_L); // R14
    if (sys_rst) begin
      next_state.hold = 4'h0;
      next_state.p_out = DEASSERTED_L;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // Open drain: drive low only while asserting.
  assign s_serr.o = ASSERTED_L;
  assign s_serr.oe = (state.hold != 4'h0);
  assign p_serr_l = state.p_out;

  property p_serr_fire;
    @(posedge clk) disable iff (sys_rst) fire |=> s_serr.oe [*3];
  endproperty
  a_serr_fire: assert property (p_serr_fire) else $error("serr not held"); // R1

  property p_serr_fwd;
    @(posedge clk) disable iff (sys_rst)
      (fwd_en && !serr_l_sync) |=> !p_serr_l;
  endproperty
  a_serr_fwd: assert property (p_serr_fwd) else $error("serr not forwarded"); // R14

endmodule : sbtt_serr

// ---- design/sbtt_top.sv ----
// Secondary bus target termination logic of a bridge, target side.
// Assumes pins resolved by the bench, frame and irdy from the bus.
//
// Overview of operation
// R1 - System error on discarded upstream delayed requests
// R2 - System error on upstream delayed master timeout
// R3 - Only the addressed target drives stop
// R4 - Stop, trdy, devsel: disconnect with data
// R5 - Stop, devsel, no trdy: disconnect without data
// R6 - No data on first phase means retry
// R7 - Stop without devsel means target abort
// R8 - Stop driven high one cycle, then released
// R9 - Only the addressed target drives trdy
// R10 - Write trdy only when data can be accepted
// R11 - Read trdy only while read data valid
// R12 - Trdy held until data phase completes
// R13 - Trdy driven high one cycle, then released
// R14 - Sample system error, forward when enabled
// R15 - Active-low signals sampled on rising clock
module sbtt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus pins from the secondary bus
  input wire logic s_frame_l,
  input wire logic s_irdy_l,
  input wire logic s_stop_l_in,
  input wire logic s_serr_l_in,
  // Bus pins driven by this target
  output sbtt_pkg::sbtt_pin_t s_stop,
  output sbtt_pkg::sbtt_pin_t s_trdy,
  output sbtt_pkg::sbtt_pin_t s_devsel,
  output sbtt_pkg::sbtt_pin_t s_serr,
  output logic p_serr_l,
  // Core side
  input wire sbtt_pkg::sbtt_treq_t treq,
  input wire logic rd_data_valid,
  input wire sbtt_pkg::sbtt_evt_t evt,
  input wire logic [2:0] serr_evt_en,
  input wire logic serr_fwd_en,
  output logic phase_done,
  output sbtt_pkg::sbtt_term_t term
);
  import sbtt_pkg::*;

  typedef enum logic [1:0] {
    SBTT_IDLE,
    SBTT_DATA,
    SBTT_TURN
  } sbtt_fsm_t;

  typedef struct packed {
    sbtt_fsm_t fsm;
    logic trdy;
    logic stop;
    logic devsel;
    logic first;
    logic done;
    sbtt_term_t term;
  } sbtt_state_t;

  sbtt_state_t state, next_state;
  logic frame_s, irdy_s, serr_s, stop_s;
  logic can_ready, xfer, ended;

  // ***********************************************************************
  // Pin synchronisers
  // ***********************************************************************
  sbtt_sync u_frame (.clk(clk), .sys_rst(sys_rst), .din(s_frame_l), .dout(frame_s)); // R15
  sbtt_sync u_irdy (.clk(clk), .sys_rst(sys_rst), .din(s_irdy_l), .dout(irdy_s)); // R15
  sbtt_sync u_serr (.clk(clk), .sys_rst(sys_rst), .din(s_serr_l_in), .dout(serr_s)); // R14
  sbtt_sync u_stop (.clk(clk), .sys_rst(sys_rst), .din(s_stop_l_in), .dout(stop_s)); // R3

  // ***********************************************************************
  // System error
  // ***********************************************************************
  sbtt_serr u_serr_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .evt(evt),
    .evt_en(serr_evt_en),
    .fwd_en(serr_fwd_en),
    .serr_l_sync(serr_s),
    .s_serr(s_serr),
    .p_serr_l(p_serr_l)
  );

  function automatic logic act(input logic lvl_l);
    act = (lvl_l == ASSERTED_L);
  endfunction : act

  // ***********************************************************************
  // Target state machine
  // ***********************************************************************
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    // Write needs room, read needs valid data.
    can_ready = treq.ready && (treq.is_write || rd_data_valid); // R10 R11
    xfer = state.trdy && act(irdy_s);
    ended = (state.stop || state.trdy) && act(irdy_s);
    case (state.fsm)
      SBTT_IDLE: begin
        next_state.trdy = 1'b0;
        next_state.stop = 1'b0;
        if (treq.active) begin
          next_state.fsm = SBTT_DATA;
          next_state.first = 1'b1;
          next_state.term = SBTT_TERM_NONE;
          next_state.devsel = (treq.kind != SBTT_REQ_ABORT);
          next_state.stop = (treq.kind == SBTT_REQ_ABORT); // R7
        end
      end
      SBTT_DATA: begin
        if (ended) begin
          next_state.done = 1'b1;
          if (state.stop && !state.devsel) begin
            next_state.term = SBTT_TERM_ABORT; // R7
          end else if (state.stop && !state.trdy) begin
            next_state.term = state.first ? SBTT_TERM_RETRY : SBTT_TERM_DISC; // R5 R6
          end else if (state.stop) begin
            next_state.term = SBTT_TERM_DISC; // R4
          end
          if (xfer) begin
            next_state.first = 1'b0;
          end
          if (state.stop || act(frame_s) == 1'b0) begin
            next_state.fsm = SBTT_TURN;
            next_state.trdy = 1'b0;
            next_state.stop = 1'b0;
            next_state.devsel = 1'b0;
          end else begin
            next_state.trdy = 1'b0;
          end
        end else if (state.trdy) begin
          next_state.trdy = 1'b1; // R12
        end else if (state.stop) begin
          next_state.stop = 1'b1; // R5 R7
        end else if (treq.kind == SBTT_REQ_DISC_NODATA) begin
          next_state.stop = 1'b1; // R5
        end else if (can_ready) begin
          next_state.trdy = 1'b1; // R9
          next_state.stop = (treq.kind == SBTT_REQ_DISC_DATA); // R4
        end
      end
      SBTT_TURN: begin
        // One cycle of driven-high, then release.
        next_state.fsm = SBTT_IDLE; // R8 R13
      end
      default: begin
        next_state.fsm = SBTT_IDLE;
      end
    endcase
    if (sys_rst) begin
      next_state.fsm = SBTT_IDLE;
      next_state.trdy = 1'b0;
      next_state.stop = 1'b0;
      next_state.devsel = 1'b0;
      next_state.first = 1'b0;
      next_state.done = 1'b0;
      next_state.term = SBTT_TERM_NONE;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ***********************************************************************
  // Pin drive
  // ***********************************************************************
  logic drive;
  assign drive = (state.fsm != SBTT_IDLE); // R3 R9
  assign s_stop.o = state.stop ? ASSERTED_L : DEASSERTED_L;
  assign s_stop.oe = drive; // R3 R8
  assign s_trdy.o = state.trdy ? ASSERTED_L : DEASSERTED_L;
  assign s_trdy.oe = drive; // R13
  assign s_devsel.o = state.devsel ? ASSERTED_L : DEASSERTED_L;
  assign s_devsel.oe = drive;
  assign phase_done = state.done;
  assign term = state.term;

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  sequence s_turn;
    state.fsm == SBTT_TURN;
  endsequence

  property p_turn_high;
    @(posedge clk) disable iff (sys_rst)
      s_turn |-> (s_stop.oe && s_stop.o && s_trdy.oe && s_trdy.o) ##1 !s_stop.oe;
  endproperty
  a_turn_high: assert property (p_turn_high) else $error("bad turnaround"); // R8

  property p_trdy_release;
    @(posedge clk) disable iff (sys_rst) s_turn |=> !s_trdy.oe;
  endproperty
  a_trdy_release: assert property (p_trdy_release) else $error("trdy not released"); // R13

  property p_trdy_hold;
    @(posedge clk) disable iff (sys_rst)
      (state.trdy && !act(irdy_s) && state.fsm == SBTT_DATA) |=> state.trdy;
  endproperty
  a_trdy_hold: assert property (p_trdy_hold) else $error("trdy dropped early"); // R12

  property p_idle_quiet;
    @(posedge clk) disable iff (sys_rst) (state.fsm == SBTT_IDLE) |-> !s_stop.oe && !s_trdy.oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle"); // R3

  property p_abort;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && ended && state.stop && !state.devsel)
        |=> term == SBTT_TERM_ABORT;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged"); // R7

  property p_retry;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && ended && state.stop && state.devsel && !state.trdy && state.first)
        |=> term == SBTT_TERM_RETRY;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not flagged"); // R6

  property p_disc_data;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && ended && state.stop && state.trdy && state.devsel)
        |=> term == SBTT_TERM_DISC;
  endproperty
  a_disc_data: assert property (p_disc_data) else $error("disconnect not flagged"); // R4

  property p_rd_valid;
    @(posedge clk) disable iff (sys_rst)
      ($rose(state.trdy) && !treq.is_write) |-> $past(rd_data_valid);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("trdy without read data"); // R11

  sequence s_last_end;
    state.fsm == SBTT_DATA && ended && (state.stop || !act(frame_s));
  endsequence

  property p_end_turn;
    @(posedge clk) disable iff (sys_rst) s_last_end |=> s_turn;
  endproperty
  a_end_turn: assert property (p_end_turn) else $error("no turnaround after end"); // R8 R13

  property p_turn_once;
    @(posedge clk) disable iff (sys_rst) s_turn |=> state.fsm == SBTT_IDLE;
  endproperty
  a_turn_once: assert property (p_turn_once) else $error("turnaround too long"); // R8 R13

  property p_end_done;
    @(posedge clk) disable iff (sys_rst) (state.fsm == SBTT_DATA && ended) |=> phase_done;
  endproperty
  a_end_done: assert property (p_end_done) else $error("phase end not reported"); // R4 R5 R7

  property p_devsel_hold;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && !ended) |=> $stable(state.devsel);
  endproperty
  a_devsel_hold: assert property (p_devsel_hold) else $error("devsel changed in phase"); // R4

  property p_abort_start;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_IDLE && treq.active && treq.kind == SBTT_REQ_ABORT)
        |=> (s_stop.o == ASSERTED_L && s_devsel.o == DEASSERTED_L);
  endproperty
  a_abort_start: assert property (p_abort_start) else $error("abort not signalled"); // R7

  property p_abort_hold;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && state.stop && !state.devsel && !ended) |=> state.stop;
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort stop dropped"); // R7

  property p_retry_no_trdy;
    @(posedge clk) disable iff (sys_rst)
      (state.fsm == SBTT_DATA && state.stop && state.devsel && !state.trdy && !ended)
        |=> !state.trdy;
  endproperty
  a_retry_no_trdy: assert property (p_retry_no_trdy) else $error("trdy after stop"); // R5

  property p_wr_ready;
    @(posedge clk) disable iff (sys_rst)
      ($rose(state.trdy) && treq.is_write) |-> $past(treq.ready);
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("trdy without write room"); // R10

  property p_trdy_in_data;
    @(posedge clk) disable iff (sys_rst) state.trdy |-> state.fsm == SBTT_DATA;
  endproperty
  a_trdy_in_data: assert property (p_trdy_in_data) else $error("trdy outside data"); // R9

  property p_stop_loop;
    @(posedge clk) disable iff (sys_rst)
      (s_stop.oe && s_stop.o == ASSERTED_L) |-> ##2 (stop_s == ASSERTED_L);
  endproperty
  a_stop_loop: assert property (p_stop_loop) else $error("stop pin not seen low"); // R3

  property p_serr_pin;
    @(posedge clk) disable iff (sys_rst) s_serr.oe |-> ##2 (serr_s == ASSERTED_L);
  endproperty
  a_serr_pin: assert property (p_serr_pin) else $error("serr pin not seen low"); // R14

endmodule : sbtt_top

// ---- tb/sbtt_init_model.sv ----
// Initiator model for one single-phase transaction on the secondary bus.
// Assumes the bench resolves the target pins with their pull-ups.
module sbtt_init_model (
  // Clock
  input wire logic clk,
  // Control from the bench
  input wire logic go,
  input wire logic [3:0] irdy_wait,
  // Resolved target pins
  input wire logic trdy_l,
  input wire logic stop_l,
  // Initiator pins
  output logic frame_l,
  output logic irdy_l
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic busy = 1'b0;
  initial begin
    frame_l = 1'b1;
    irdy_l = 1'b1;
  end
  // Frame goes high as irdy goes low, marking the only data phase as the last.
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      frame_l <= 1'b0;
      cnt <= irdy_wait;
    end else if (busy && irdy_l && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy && irdy_l) begin
      irdy_l <= 1'b0;
      frame_l <= 1'b1;
    end else if (busy && (!trdy_l || !stop_l)) begin
      irdy_l <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule : sbtt_init_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the target termination block.
// Assumes the initiator model in sbtt_init_model and pull-ups on all pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbtt_pkg::*;
  // ***********************************************************************
  // Signals
  // ***********************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic [3:0] irdy_wait = 4'h0;
  logic frame_l;
  logic irdy_l;
  logic serr_pull = 1'b0;
  logic rd_data_valid = 1'b0;
  logic [2:0] serr_evt_en = 3'h0;
  logic serr_fwd_en = 1'b0;
  sbtt_treq_t treq = '0;
  sbtt_evt_t evt = '0;
  sbtt_pin_t s_stop;
  sbtt_pin_t s_trdy;
  sbtt_pin_t s_devsel;
  sbtt_pin_t s_serr;
  sbtt_term_t term;
  logic p_serr_l;
  logic phase_done;
  int n_fail = 0;
  int samples_checked = 0;
  wire logic stop_w = s_stop.oe ? s_stop.o : 1'b1;
  wire logic trdy_w = s_trdy.oe ? s_trdy.o : 1'b1;
  wire logic devsel_w = s_devsel.oe ? s_devsel.o : 1'b1;
  wire logic serr_w = (s_serr.oe || serr_pull) ? 1'b0 : 1'b1;
  always #4 clk = ~clk;
  sbtt_top sbtt_top_i (.clk(clk), .sys_rst(sys_rst), .s_frame_l(frame_l), .s_irdy_l(irdy_l),
    .s_stop_l_in(stop_w), .s_serr_l_in(serr_w), .s_stop(s_stop), .s_trdy(s_trdy),
    .s_devsel(s_devsel), .s_serr(s_serr), .p_serr_l(p_serr_l), .treq(treq),
    .rd_data_valid(rd_data_valid), .evt(evt), .serr_evt_en(serr_evt_en),
    .serr_fwd_en(serr_fwd_en), .phase_done(phase_done), .term(term));
  sbtt_init_model sbtt_init_model_i (.clk(clk), .go(go), .irdy_wait(irdy_wait),
    .trdy_l(trdy_w), .stop_l(stop_w), .frame_l(frame_l), .irdy_l(irdy_l));
  // ***********************************************************************
  // Tasks
  // ***********************************************************************
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Flags: trdy seen, stop seen, devsel seen, trdy dropped before the end.
  task automatic run_phase(input sbtt_req_t kind, input logic wr, input int hold,
    input logic [3:0] wt, input logic [3:0] exp_pins, input sbtt_term_t exp_term);
    logic st;
    logic sp;
    logic dv;
    logic dr;
    logic early;
    int i;
    {st, sp, dv, dr, early} = 5'h00;
    @(posedge clk);
    treq <= '{active: 1'b1, is_write: wr, ready: (hold == 0), kind: kind};
    rd_data_valid <= (hold == 0);
    irdy_wait <= wt;
    go <= 1'b1;
    for (i = 0; i < 60 && phase_done !== 1'b1; i++) begin
      @(posedge clk);
      go <= 1'b0;
      if (i == hold) begin
        treq.ready <= 1'b1;
        rd_data_valid <= 1'b1;
      end
      #1;
      if (hold > 0 && i <= hold && trdy_w === 1'b0) early = 1'b1;
      if (st && trdy_w !== 1'b0 && phase_done !== 1'b1) dr = 1'b1;
      st = st | (trdy_w === 1'b0);
      sp = sp | (stop_w === 1'b0);
      dv = dv | (devsel_w === 1'b0);
    end
    chk({3'h0, phase_done}, 4'h1, "phase end");
    chk({s_stop.o, s_stop.oe, s_trdy.o, s_trdy.oe}, 4'hF, "turn level");
    chk({2'h0, term}, {2'h0, exp_term}, "term code");
    chk({st, sp, dv, dr}, exp_pins, "pin pattern");
    chk({3'h0, early}, 4'h0, "early trdy");
    @(posedge clk);
    treq.active <= 1'b0;
    #1;
    chk({1'h0, s_stop.oe, s_trdy.oe, s_devsel.oe}, 4'h0, "release");
  endtask : run_phase
  task automatic run_serr;
    logic [3:0] cnt;
    int b;
    int e;
    for (b = 0; b < 6; b++) begin
      @(posedge clk);
      serr_evt_en <= (b < 3) ? (3'h1 << b) : ~(3'h1 << (b - 3));
      evt <= sbtt_evt_t'(3'h1 << (b % 3));
      cnt = 4'h0;
      for (e = 0; e < 10; e++) begin
        @(posedge clk);
        evt <= '0;
        #1;
        if (s_serr.oe === 1'b1 && s_serr.o === 1'b0) cnt++;
      end
      chk(cnt, (b < 3) ? SERR_EVT_W : 4'h0, "serr width");
    end
    for (b = 0; b < 2; b++) begin
      @(posedge clk);
      serr_fwd_en <= (b == 0);
      serr_pull <= 1'b1;
      cnt = 4'h0;
      for (e = 0; e < 10; e++) begin
        @(posedge clk);
        if (e == 3) serr_pull <= 1'b0;
        #1;
        if (p_serr_l === 1'b0) cnt++;
      end
      chk(cnt, (b == 0) ? 4'h4 : 4'h0, "serr forward");
    end
  endtask : run_serr
  // ***********************************************************************
  // Sequence
  // ***********************************************************************
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({s_stop.oe, s_trdy.oe, s_devsel.oe, phase_done}, 4'h0, "reset pins");
    run_phase(SBTT_REQ_TRDY, 1'b1, 0, 4'h0, 4'hA, SBTT_TERM_NONE);
    run_phase(SBTT_REQ_TRDY, 1'b0, 6, 4'h0, 4'hA, SBTT_TERM_NONE);
    run_phase(SBTT_REQ_TRDY, 1'b1, 4, 4'h5, 4'hA, SBTT_TERM_NONE);
    run_phase(SBTT_REQ_DISC_DATA, 1'b0, 0, 4'h0, 4'hE, SBTT_TERM_DISC);
    run_phase(SBTT_REQ_DISC_NODATA, 1'b1, 0, 4'h0, 4'h6, SBTT_TERM_RETRY);
    run_phase(SBTT_REQ_ABORT, 1'b1, 0, 4'h0, 4'h4, SBTT_TERM_ABORT);
    run_serr();
    give_verdict();
  end
endmodule : tb_top
